// ### core/msh_motion_ctrl.sv
// Behaviour
// - commands start motion and acknowledge at once
// - wait step advances on motion end or idle
// - wait step loops while moving flag is one
// - motion commands refused while motion active
// - missing end signal while waiting raises 6Fh
// - homing ties position zero to reference
// - positive seek starts positive, negative starts negative
// - pattern 12 takes direction from driver
// - seek may reverse before finishing, per pattern
// - final approach matches starting direction
// - unmapped inputs block homing, error or 70h
// - success clears position, sets found flag, output
// - velocities and ramp times latched at start
module msh_motion_ctrl #(
  parameter int VEL_W = 16,
  parameter int TIME_W = 16,
  parameter int END_WAIT_CYCLES = msh_pkg::END_WAIT_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_sequence_mode, // 1: running a sequence, 0: immediate
  input wire logic i_cmd_move, // start a plain motion
  input wire logic i_move_dir, // direction of a plain motion, 1 positive
  input wire logic i_seek_reference_positive,
  input wire logic i_seek_reference_negative,
  input wire logic i_wait_motion_done, // wait step executes
  input wire logic i_stop, // stop the active motion
  input wire logic i_alarm_clear,
  input wire logic [3:0] i_homing_pattern_select,
  input wire logic i_driver_dir, // driver direction setting, 1 positive
  input wire logic i_assign_pos_limit,
  input wire logic i_assign_neg_limit,
  input wire logic i_assign_reference,
  input wire logic i_home_out_enable,
  input wire logic i_profile_done, // generator finished its profile
  input wire logic i_positive_limit_input, // pin
  input wire logic i_negative_limit_input, // pin
  input wire logic i_reference_input, // pin
  input wire logic i_end_input, // driver end pin
  input wire logic [VEL_W-1:0] i_start_velocity,
  input wire logic [VEL_W-1:0] i_run_velocity,
  input wire logic [TIME_W-1:0] i_accel_time,
  input wire logic [TIME_W-1:0] i_decel_time,
  output logic o_cmd_ack,
  output logic o_cmd_refused,
  output logic o_cmd_error,
  output logic o_step_advance,
  output logic o_wait_busy,
  output logic o_moving_flag,
  output logic o_run,
  output logic o_dir,
  output logic o_position_command_clear,
  output logic o_reference_found_flag,
  output logic o_home_found_out,
  output logic o_alarm_active,
  output logic [7:0] o_alarm_code,
  output logic [VEL_W-1:0] o_start_velocity,
  output logic [VEL_W-1:0] o_run_velocity,
  output logic [TIME_W-1:0] o_accel_time,
  output logic [TIME_W-1:0] o_decel_time
);

  localparam int CW = $clog2(END_WAIT_CYCLES + 1);
  localparam logic [CW-1:0] CNT_LAST = CW'(END_WAIT_CYCLES - 1);

  typedef struct packed {
    msh_pkg::msh_state_e st;
    logic start_dir; // direction the seek began in
    logic dir;
    logic run;
    logic home; // active motion is a home seek
    logic seen_ref; // reference met at the turn or while backing off
    logic end_low; // end pin seen low since this motion began
    logic moving;
    logic waiting;
    logic advance;
    logic ack;
    logic refused;
    logic err;
    logic pos_clr;
    logic ref_found;
    logic home_out;
    logic alarm;
    logic [7:0] code;
    logic [CW-1:0] cnt;
    logic [VEL_W-1:0] vs;
    logic [VEL_W-1:0] vr;
    logic [TIME_W-1:0] ta;
    logic [TIME_W-1:0] td;
  } msh_ctrl_s;

  msh_ctrl_s q;
  msh_ctrl_s d;
  logic [msh_pkg::PIN_COUNT-1:0] pins;
  logic lim_pos;
  logic lim_neg;
  logic ref_lvl;
  logic end_lvl;
  logic any_cmd;
  logic seek_req;
  logic [2:0] missing;

  // ==========================================================================
  // inputs needed by each homing pattern
  // ==========================================================================
  // the driver-run pattern needs nothing of ours; the others need the
  // reference switch, and the higher ones also both limits
  function automatic logic [2:0] need_inputs(input logic [3:0] pat);
    logic [2:0] m;
    m = '0;
    if (pat != msh_pkg::PATTERN_DRIVER) begin
      m[msh_pkg::NEED_REFERENCE] = 1'b1;
      if (pat >= msh_pkg::PATTERN_LIMITS_MIN) begin
        m[msh_pkg::NEED_POS_LIMIT] = 1'b1;
        m[msh_pkg::NEED_NEG_LIMIT] = 1'b1;
      end
    end
    return m;
  endfunction

  // ==========================================================================
  // pin synchronisers
  // ==========================================================================
  msh_pin_sync #(
    .WIDTH(msh_pkg::PIN_COUNT)
  ) u_sync (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_pin({i_end_input, i_reference_input, i_negative_limit_input, i_positive_limit_input}),
    .o_level(pins)
  );

  assign lim_pos = pins[msh_pkg::PIN_POS_LIMIT];
  assign lim_neg = pins[msh_pkg::PIN_NEG_LIMIT];
  assign ref_lvl = pins[msh_pkg::PIN_REFERENCE];
  assign end_lvl = pins[msh_pkg::PIN_END];
  assign seek_req = i_seek_reference_positive | i_seek_reference_negative;
  assign any_cmd = i_cmd_move | seek_req;
  // a pattern is usable only once the user mapped its inputs
  assign missing = need_inputs(i_homing_pattern_select) &
                   ~{i_assign_pos_limit, i_assign_neg_limit, i_assign_reference};

  // ==========================================================================
  // next state
  // ==========================================================================
  always_comb begin
    d = q;
    d.advance = 1'b0;
    d.ack = 1'b0;
    d.refused = 1'b0;
    d.err = 1'b0;
    d.pos_clr = 1'b0;
    // clear first so that any alarm raised below in the same cycle wins
    if (i_alarm_clear) begin
      d.alarm = 1'b0;
    end
    // command intake: refuse when busy, in alarm or a seek lacks its inputs, else start and return
    if (any_cmd && (q.st != msh_pkg::MSH_IDLE || q.alarm)) begin
      d.refused = 1'b1;
      if (i_sequence_mode) begin
        d.alarm = 1'b1;
        d.code = msh_pkg::ALARM_MOTION_BUSY;
      end else begin
        d.err = 1'b1;
      end
    end else if (seek_req && (|missing)) begin
      d.refused = 1'b1;
      if (i_sequence_mode) begin
        d.alarm = 1'b1;
        d.code = msh_pkg::ALARM_NO_INPUTS;
      end else begin
        d.err = 1'b1;
      end
    end else if (any_cmd) begin
      // every motion latches its profile and reports back at once
      d.ack = 1'b1;
      d.moving = 1'b1;
      d.end_low = 1'b0;
      d.run = 1'b1;
      d.vs = i_start_velocity;
      d.vr = i_run_velocity;
      d.ta = i_accel_time;
      d.td = i_decel_time;
      if (seek_req) begin
        // positive wins when both seek commands arrive together
        d.home = 1'b1;
        d.ref_found = 1'b0;
        d.start_dir = i_seek_reference_positive;
        d.st = msh_pkg::MSH_SEEK;
        if (i_homing_pattern_select == msh_pkg::PATTERN_DRIVER) begin
          d.start_dir = i_driver_dir;
          d.st = msh_pkg::MSH_DRV_HOME;
        end
        d.dir = d.start_dir;
      end else begin
        d.home = 1'b0;
        d.dir = i_move_dir;
        d.st = msh_pkg::MSH_MOVE;
      end
    end
    // the synchronised end level lags the pin, so a level left over from
    // before the motion must not end a short or stopped motion early
    if (q.moving && !end_lvl) begin
      d.end_low = 1'b1;
    end
    // motion progress
    unique case (q.st)
      msh_pkg::MSH_IDLE: begin
      end
      msh_pkg::MSH_MOVE, msh_pkg::MSH_DRV_HOME: begin
        if (i_profile_done) begin
          d.run = 1'b0;
          d.cnt = '0;
          d.st = msh_pkg::MSH_END_CHK;
        end
      end
      msh_pkg::MSH_SEEK: begin
        // forward limit or reference turns the seek round
        if (ref_lvl || (q.start_dir ? lim_pos : lim_neg)) begin
          d.dir = ~q.start_dir;
          d.seen_ref = ref_lvl;
          d.st = msh_pkg::MSH_BACKOFF;
        end
      end
      msh_pkg::MSH_BACKOFF: begin
        if (ref_lvl) begin
          d.seen_ref = 1'b1;
        end else if (q.seen_ref) begin
          // clear of the reference: come back onto it the original way
          d.dir = q.start_dir;
          d.st = msh_pkg::MSH_APPROACH;
        end
      end
      msh_pkg::MSH_APPROACH: begin
        if (ref_lvl) begin
          d.run = 1'b0;
          d.cnt = '0;
          d.st = msh_pkg::MSH_END_CHK;
        end
      end
      msh_pkg::MSH_END_CHK: begin
        // the motion counts as ended once the driver confirms it, or at the give-up below
        if (end_lvl && q.end_low) begin
          d.moving = 1'b0;
          d.st = msh_pkg::MSH_IDLE;
          if (q.home) begin
            d.pos_clr = 1'b1;
            d.ref_found = 1'b1;
          end
          d.home = 1'b0;
        end else if (q.cnt == CNT_LAST) begin
          // give up so that the sequencer is never stuck for good
          d.moving = 1'b0;
          d.home = 1'b0;
          d.st = msh_pkg::MSH_IDLE;
          if (q.waiting) begin
            d.alarm = 1'b1;
            d.code = msh_pkg::ALARM_END_MISSING;
          end
        end else begin
          d.cnt = q.cnt + 1'b1;
        end
      end
    endcase
    // a stop ends any running phase; a stopped seek is not a success
    if (i_stop && q.run) begin
      d.run = 1'b0;
      d.home = 1'b0;
      d.cnt = '0;
      d.st = msh_pkg::MSH_END_CHK;
    end
    // wait step: same as looping while the moving flag is one
    if (i_wait_motion_done && !q.moving) begin
      d.advance = 1'b1;
    end else if (i_wait_motion_done) begin
      d.waiting = 1'b1;
    end
    if (q.waiting && !q.moving) begin
      d.waiting = 1'b0;
      d.advance = 1'b1;
    end
    d.home_out = d.ref_found & i_home_out_enable;
  end

  // ==========================================================================
  // state register
  // ==========================================================================
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ==========================================================================
  // outputs
  // ==========================================================================
  assign o_cmd_ack = q.ack;
  assign o_cmd_refused = q.refused;
  assign o_cmd_error = q.err;
  assign o_step_advance = q.advance;
  assign o_wait_busy = q.waiting;
  assign o_moving_flag = q.moving;
  assign o_run = q.run;
  assign o_dir = q.dir;
  assign o_position_command_clear = q.pos_clr;
  assign o_reference_found_flag = q.ref_found;
  assign o_home_found_out = q.home_out;
  assign o_alarm_active = q.alarm;
  assign o_alarm_code = q.code;
  assign o_start_velocity = q.vs;
  assign o_run_velocity = q.vr;
  assign o_accel_time = q.ta;
  assign o_decel_time = q.td;

  // ==========================================================================
  // assertions
  // ==========================================================================
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  property p_move_ack;
    (q.st == msh_pkg::MSH_IDLE && !q.alarm && i_cmd_move && !seek_req && !i_stop)
      |=> o_cmd_ack && o_run && o_moving_flag;
  endproperty
  a_move_ack: assert property (p_move_ack) else $error("move not started at once");

  property p_wait_idle;
    (i_wait_motion_done && !o_moving_flag) |=> o_step_advance;
  endproperty
  a_wait_idle: assert property (p_wait_idle) else $error("idle wait did not advance");

  property p_wait_loop;
    o_wait_busy |-> (o_moving_flag ##1 !o_step_advance) or (!o_moving_flag ##1 o_step_advance);
  endproperty
  a_wait_loop: assert property (p_wait_loop) else $error("wait loop misbehaved");

  property p_busy_refuse;
    (q.st != msh_pkg::MSH_IDLE && any_cmd) |=> o_cmd_refused && !o_cmd_ack;
  endproperty
  a_busy_refuse: assert property (p_busy_refuse) else $error("busy command taken");

  property p_end_alarm;
    (q.st == msh_pkg::MSH_END_CHK && q.waiting && !end_lvl && q.cnt == CNT_LAST)
      |=> o_alarm_active && o_alarm_code == msh_pkg::ALARM_END_MISSING;
  endproperty
  a_end_alarm: assert property (p_end_alarm) else $error("no 6Fh alarm");

  property p_seek_dir;
    (q.st == msh_pkg::MSH_IDLE && !q.alarm && seek_req && missing == 3'h0)
      |=> o_dir == ((i_homing_pattern_select == msh_pkg::PATTERN_DRIVER) ?
                    $past(i_driver_dir) : $past(i_seek_reference_positive));
  endproperty
  a_seek_dir: assert property (p_seek_dir) else $error("wrong seek direction");

  property p_approach_dir;
    (q.st == msh_pkg::MSH_APPROACH) |-> o_dir == q.start_dir;
  endproperty
  a_approach_dir: assert property (p_approach_dir) else $error("approach reversed");

  property p_no_inputs;
    (q.st == msh_pkg::MSH_IDLE && !q.alarm && seek_req && missing != 3'h0 && i_sequence_mode)
      |=> o_alarm_code == msh_pkg::ALARM_NO_INPUTS && !o_run;
  endproperty
  a_no_inputs: assert property (p_no_inputs) else $error("homing without inputs");

  property p_home_done;
    (q.st == msh_pkg::MSH_END_CHK && q.home && end_lvl && q.end_low)
      |=> o_reference_found_flag && o_position_command_clear && !o_moving_flag;
  endproperty
  a_home_done: assert property (p_home_done) else $error("home success missed");

  property p_latched;
    (o_moving_flag && $past(o_moving_flag)) |-> $stable(o_run_velocity) && $stable(o_accel_time);
  endproperty
  a_latched: assert property (p_latched) else $error("profile changed in motion");

  property p_run_moving;
    o_run |-> o_moving_flag;
  endproperty
  a_run_moving: assert property (p_run_moving) else $error("running while not moving");

endmodule

// ### core/msh_pkg.sv
package msh_pkg;

  // ==========================================================================
  // alarm and error codes
  // ==========================================================================
  localparam logic [7:0] ALARM_END_MISSING = 8'h6F; // end signal never came
  localparam logic [7:0] ALARM_NO_INPUTS = 8'h70; // homing inputs not mapped
  localparam logic [7:0] ALARM_MOTION_BUSY = 8'hA0; // motion refused in a sequence
  localparam logic [7:0] ALARM_CODE_RESET = 8'h00; // code shown after reset

  // ==========================================================================
  // homing patterns
  // ==========================================================================
  localparam logic [3:0] PATTERN_DRIVER = 4'hC; // pattern 12, driver decides direction
  localparam logic [3:0] PATTERN_LIMITS_MIN = 4'h4; // from here on both limits are needed, save pattern 12

  // ==========================================================================
  // bit positions of the input-need mask
  // ==========================================================================
  localparam int NEED_POS_LIMIT = 2;
  localparam int NEED_NEG_LIMIT = 1;
  localparam int NEED_REFERENCE = 0;

  // ==========================================================================
  // pin bundle positions through the synchroniser
  // ==========================================================================
  localparam int PIN_POS_LIMIT = 0;
  localparam int PIN_NEG_LIMIT = 1;
  localparam int PIN_REFERENCE = 2;
  localparam int PIN_END = 3;
  localparam int PIN_COUNT = 4;

  // ==========================================================================
  // timing
  // ==========================================================================
  localparam int CLK_MHZ = 125; // 8 ns period
  localparam int END_WAIT_US = 1000; // longest wait for the end signal
  localparam int END_WAIT_CYCLES = END_WAIT_US * CLK_MHZ; // longest time in clock cycles, an exact product

  // ==========================================================================
  // sequencer states
  // ==========================================================================
  typedef enum logic [2:0] {
    MSH_IDLE,
    MSH_MOVE,
    MSH_SEEK,
    MSH_BACKOFF,
    MSH_APPROACH,
    MSH_DRV_HOME,
    MSH_END_CHK
  } msh_state_e;

endpackage

// ### core/msh_pin_sync.sv
// ============================================================================
// three-stage pin synchroniser with agreement filter
// ============================================================================
module msh_pin_sync #(
  parameter int WIDTH = 4
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic [WIDTH-1:0] i_pin,
  output logic [WIDTH-1:0] o_level
);

  typedef struct packed {
    logic [WIDTH-1:0] s1; // metastable stage, read only by s2
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] lvl; // accepted level
  } msh_sync_s;

  msh_sync_s q;
  msh_sync_s d;

  // ==========================================================================
  // next state
  // ==========================================================================
  // a change is taken only once stages two and three agree, which drops
  // single-cycle glitches at the price of one extra cycle of latency
  always_comb begin
    d = q;
    d.s1 = i_pin;
    d.s2 = q.s1;
    d.s3 = q.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (q.s2[i] == q.s3[i]) begin
        d.lvl[i] = q.s3[i];
      end
    end
  end

  // ==========================================================================
  // state register
  // ==========================================================================
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_level = q.lvl;

endmodule

// ### testbench/msh_drive_model.sv
// ============================================================================
// motor driver with limit and reference switches
// ============================================================================
module msh_drive_model #(
  parameter int MOVE_LEN = 40, // run cycles until a plain profile ends
  parameter int END_DLY = 3, // settling cycles before end is shown
  parameter int REF_LO = 30, // reference switch window, in steps
  parameter int REF_HI = 39,
  parameter int LIM_POS = 80, // limit switch positions
  parameter int LIM_NEG = -60
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_run,
  input wire logic i_dir,
  input wire logic i_end_silent, // scenario switch: end is never reported
  output logic o_profile_done,
  output logic o_positive_limit_input,
  output logic o_negative_limit_input,
  output logic o_reference_input,
  output logic o_end_input
);
  timeunit 1ns;
  timeprecision 1ps;
  int pos_q; // shaft position, one step a cycle
  int run_cnt_q; // cycles since run rose
  int settle_q; // cycles since run fell
  // one step per cycle in the commanded direction; end shows only after settling
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pos_q <= 0;
      run_cnt_q <= 0;
      settle_q <= 0;
      o_profile_done <= 1'h0;
    end else begin
      o_profile_done <= i_run && (run_cnt_q == MOVE_LEN - 1);
      if (i_run) begin
        pos_q <= i_dir ? pos_q + 1 : pos_q - 1;
        run_cnt_q <= run_cnt_q + 1;
        settle_q <= 0;
      end else begin
        run_cnt_q <= 0;
        settle_q <= (settle_q < END_DLY) ? settle_q + 1 : settle_q;
      end
    end
  end
  // switches are plain levels of position; end is low whenever the shaft moves
  assign o_reference_input = (pos_q >= REF_LO) && (pos_q <= REF_HI);
  assign o_positive_limit_input = pos_q >= LIM_POS;
  assign o_negative_limit_input = pos_q <= LIM_NEG;
  assign o_end_input = !i_run && (settle_q == END_DLY) && !i_end_silent;
endmodule

// ### testbench/msh_motion_ctrl_bench.sv
// ============================================================================
// bench for the motion sequencing block
// ============================================================================
module msh_motion_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int END_WAIT = 20; // short end-check window keeps the run brief
  logic i_clk, i_resetn, i_sequence_mode, i_cmd_move, i_move_dir;
  logic i_seek_reference_positive, i_seek_reference_negative, i_wait_motion_done;
  logic i_stop, i_alarm_clear, i_driver_dir, i_assign_pos_limit, i_assign_neg_limit;
  logic i_assign_reference, i_home_out_enable, end_silent;
  logic [3:0] i_homing_pattern_select;
  logic [15:0] i_start_velocity, i_run_velocity, i_accel_time, i_decel_time;
  logic i_profile_done, i_positive_limit_input, i_negative_limit_input;
  logic i_reference_input, i_end_input;
  logic o_cmd_ack, o_cmd_refused, o_cmd_error, o_step_advance, o_wait_busy;
  logic o_moving_flag, o_run, o_dir, o_position_command_clear, o_reference_found_flag;
  logic o_home_found_out, o_alarm_active;
  logic [7:0] o_alarm_code;
  logic [15:0] o_start_velocity, o_run_velocity, o_accel_time, o_decel_time;
  logic run_prev, dir_prev, dir_at_stop; // motion monitor state
  int flips, clears; // direction reversals and position clears seen
  int err_total = 0;
  int samples_checked = 0;

  msh_motion_ctrl #(.END_WAIT_CYCLES(END_WAIT)) uut (
    .i_clk, .i_resetn, .i_sequence_mode, .i_cmd_move, .i_move_dir,
    .i_seek_reference_positive, .i_seek_reference_negative, .i_wait_motion_done,
    .i_stop, .i_alarm_clear, .i_homing_pattern_select, .i_driver_dir,
    .i_assign_pos_limit, .i_assign_neg_limit, .i_assign_reference, .i_home_out_enable,
    .i_profile_done, .i_positive_limit_input, .i_negative_limit_input,
    .i_reference_input, .i_end_input, .i_start_velocity, .i_run_velocity,
    .i_accel_time, .i_decel_time, .o_cmd_ack, .o_cmd_refused, .o_cmd_error,
    .o_step_advance, .o_wait_busy, .o_moving_flag, .o_run, .o_dir,
    .o_position_command_clear, .o_reference_found_flag, .o_home_found_out,
    .o_alarm_active, .o_alarm_code, .o_start_velocity, .o_run_velocity,
    .o_accel_time, .o_decel_time
  );

  msh_drive_model drv (
    .i_clk, .i_resetn, .i_run(o_run), .i_dir(o_dir), .i_end_silent(end_silent),
    .o_profile_done(i_profile_done), .o_positive_limit_input(i_positive_limit_input),
    .o_negative_limit_input(i_negative_limit_input), .o_reference_input(i_reference_input),
    .o_end_input(i_end_input)
  );

  // ==========================================================================
  // clock, watchdog and motion monitor
  // ==========================================================================
  always #4 i_clk = ~i_clk;

  // a hang in any wait loop ends up here instead of running forever
  initial begin
    repeat (20000) @(posedge i_clk);
    err_total++;
    $display("[FAIL] %0t ns: watchdog expired", $time);
    stop_test();
  end

  // direction held while running is remembered at the moment run drops
  always @(negedge i_clk) begin
    if (run_prev === 1'h1 && o_run === 1'h0) dir_at_stop = dir_prev;
    if (run_prev === 1'h1 && o_run === 1'h1 && o_dir !== dir_prev) flips++;
    if (o_position_command_clear === 1'h1) clears++;
    run_prev = o_run;
    dir_prev = o_dir;
  end

  // ==========================================================================
  // access tasks; all but the watchdog's call of stop_test are entered just after a falling edge
  // ==========================================================================
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t ns: %s", $time, what);
    end
  endtask

  // kind 0 plain move, 1 positive seek, 2 negative seek; answer read one cycle on
  task automatic cmd(input int k, output logic a, output logic r, output logic e);
    if (k == 0) i_cmd_move = 1'h1;
    else if (k == 1) i_seek_reference_positive = 1'h1;
    else i_seek_reference_negative = 1'h1;
    @(negedge i_clk);
    a = o_cmd_ack;
    r = o_cmd_refused;
    e = o_cmd_error;
    {i_cmd_move, i_seek_reference_positive, i_seek_reference_negative} = 3'h0;
  endtask

  task automatic pulse_clear();
    i_alarm_clear = 1'h1;
    @(negedge i_clk);
    i_alarm_clear = 1'h0;
    chk(o_alarm_active, 1'h0, "alarm clear");
  endtask

  // wait step: advance at once when idle, else only after the moving flag drops
  task automatic wait_motion_done(input logic idle);
    int n;
    n = 0;
    i_wait_motion_done = 1'h1;
    @(negedge i_clk);
    i_wait_motion_done = 1'h0;
    if (idle) begin
      chk(o_step_advance, 1'h1, "advance when idle");
    end else begin
      chk(o_wait_busy, 1'h1, "wait step suspended");
      while (o_moving_flag !== 1'h0 && n < 1000) begin
        chk(o_step_advance, 1'h0, "advance while moving");
        @(negedge i_clk);
        n++;
      end
      @(negedge i_clk);
      chk({o_step_advance, o_wait_busy}, 2'h2, "advance after motion end");
    end
  endtask

  task automatic stop_test();
    $display("comparisons %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ==========================================================================
  // scenarios
  // ==========================================================================
  initial begin
    logic a, r, e;
    i_clk = 1'h0;
    i_resetn = 1'h0;
    {i_sequence_mode, i_cmd_move, i_move_dir, i_seek_reference_positive,
     i_seek_reference_negative, i_wait_motion_done, i_stop, i_alarm_clear, i_driver_dir,
     i_assign_pos_limit, i_assign_neg_limit, i_assign_reference, i_home_out_enable,
     end_silent} = 14'h0;
    i_homing_pattern_select = 4'h1;
    {i_start_velocity, i_run_velocity, i_accel_time, i_decel_time} = 64'h0123_4567_89AB_CDEF;
    repeat (5) @(negedge i_clk);
    chk({o_moving_flag, o_run, o_alarm_active, o_alarm_code}, 11'h0, "reset values");
    repeat (5) @(negedge i_clk);
    i_resetn = 1'h1;
    repeat (6) @(negedge i_clk);
    wait_motion_done(1'h1);
    // negative move runs its full profile; later edits to the profile are ignored
    cmd(0, a, r, e);
    chk({a, r, o_moving_flag, o_run, o_dir}, 5'h16, "move accepted");
    {i_start_velocity, i_run_velocity, i_accel_time, i_decel_time} = 64'h1111_2222_3333_4444;
    @(negedge i_clk);
    chk({o_start_velocity, o_run_velocity, o_accel_time, o_decel_time},
        64'h0123_4567_89AB_CDEF, "profile latched at start");
    cmd(0, a, r, e);
    chk({a, r, e, o_alarm_active, o_moving_flag}, 5'h0D, "busy refusal, immediate");
    wait_motion_done(1'h0);
    chk(o_alarm_active, 1'h0, "no alarm when end arrives");
    // in a sequence a busy refusal raises an alarm; stop keeps motion until settled
    i_sequence_mode = 1'h1;
    i_move_dir = 1'h1;
    cmd(0, a, r, e);
    chk({a, o_dir}, 2'h3, "positive move");
    cmd(1, a, r, e);
    chk({r, o_alarm_active, o_alarm_code}, 10'h3A0, "busy refusal, sequence");
    i_stop = 1'h1;
    @(negedge i_clk);
    i_stop = 1'h0;
    chk({o_run, o_moving_flag}, 2'h1, "stop drops run, motion still active");
    pulse_clear();
    wait_motion_done(1'h0);
    // seeks refused when required inputs are missing
    cmd(1, a, r, e);
    chk({a, r, o_moving_flag, o_alarm_code}, 11'h270, "unmapped inputs, sequence");
    pulse_clear();
    i_sequence_mode = 1'h0;
    cmd(2, a, r, e);
    chk({a, r, e}, 3'h3, "no reference mapped, immediate");
    i_homing_pattern_select = 4'h4;
    i_assign_reference = 1'h1;
    cmd(2, a, r, e);
    chk({a, r, e, o_moving_flag}, 4'h6, "limits missing for pattern 4");
    // negative seek with limits; reverses at the limit and finishes negative
    {i_assign_pos_limit, i_assign_neg_limit, i_home_out_enable} = 3'h7;
    flips = 0;
    clears = 0;
    cmd(2, a, r, e);
    chk({a, o_dir}, 2'h2, "negative seek starts negative");
    wait_motion_done(1'h0);
    chk({flips > 0, dir_at_stop, clears == 1, o_reference_found_flag, o_home_found_out},
        5'h17, "negative homing result");
    // positive seek from inside the switch window
    i_homing_pattern_select = 4'h1;
    clears = 0;
    cmd(1, a, r, e);
    chk({a, o_dir, o_reference_found_flag}, 3'h6, "positive seek starts positive");
    wait_motion_done(1'h0);
    chk({dir_at_stop, o_reference_found_flag, clears == 1}, 3'h7, "positive homing");
    // driver-run pattern takes its direction from the driver setting
    i_homing_pattern_select = 4'hC;
    {i_assign_pos_limit, i_assign_neg_limit, i_assign_reference, i_driver_dir} = 4'h0;
    cmd(1, a, r, e);
    chk({a, o_dir}, 2'h2, "driver decides direction");
    wait_motion_done(1'h0);
    chk(o_reference_found_flag, 1'h1, "driver-run homing found");
    // end signal never arrives while a wait step is pending
    end_silent = 1'h1;
    cmd(0, a, r, e);
    chk(a, 1'h1, "move for missing end");
    wait_motion_done(1'h0);
    chk({o_alarm_active, o_alarm_code}, 9'h16F, "missing end alarm");
    end_silent = 1'h0;
    pulse_clear();
    repeat (5) @(negedge i_clk);
    stop_test();
  end
endmodule
